// File: csms_map.vh
`ifndef CSMS_MAP_VH
`define CSMS_MAP_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CSMS_CLK_MHZ 10
// clock-enable delay after power-good seen, in microseconds
`define CSMS_CPU_CLOCK_ENABLE_NOT_US 50
`define CSMS_CPU_CLOCK_ENABLE_NOT_CYC (`CSMS_CPU_CLOCK_ENABLE_NOT_US * `CSMS_CLK_MHZ)
// power-good hold after clock enable, in milliseconds
`define CSMS_PGOOD_MS 3
`define CSMS_PGOOD_CYC (`CSMS_PGOOD_MS * 1000 * `CSMS_CLK_MHZ)
// slew ticks from arrival to driver disable, and to pulse skipping
`define CSMS_SUS_DDO_TICKS 6'h20
`define CSMS_SUS_SKIP_TICKS 6'h3E

// ----------------------------------------
// code ladder (one step is 16 mV, level 0 is ground)
// ----------------------------------------
`define CSMS_VID_TOP 8'h6B
`define CSMS_SUS_TOP 8'h5B
`define CSMS_BOOT_TOP 8'h5B

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define CSMS_REG_CTRL 8'h00
`define CSMS_REG_STATUS 8'h04
`define CSMS_REG_CODE 8'h08
`define CSMS_CTRL_SKIP_INHIBIT 0
`define CSMS_CTRL_RESET 1'h0
`define CSMS_STAT_FAULT 6
`define CSMS_STAT_PGOOD 7
`define CSMS_STAT_ARRIVED 8

`endif

// File: csms_slew.v
`timescale 1ns/1ps
`include "csms_map.vh"

// ----------------------------------------
// slew controller: one code step per tick
// ----------------------------------------
module csms_slew #(
  parameter W = 8
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_tick,
  input wire i_clear,
  input wire [W-1:0] i_target,
  output reg [W-1:0] o_code,
  output wire o_arrived
);

  reg [W-1:0] next_code;

  // step toward target on each tick
  always @* begin
    next_code = o_code;
    if (i_clear) begin
      next_code = {W{1'b0}};
    end else if (i_tick && (o_code < i_target)) begin
      next_code = o_code + {{(W-1){1'b0}}, 1'b1}; // [R24]
    end else if (i_tick && (o_code > i_target)) begin
      next_code = o_code - {{(W-1){1'b0}}, 1'b1}; // [R24]
    end
  end

  // current code register
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_code <= {W{1'b0}};
    end else begin
      o_code <= next_code;
    end
  end

  // arrival flag
  assign o_arrived = (o_code == i_target); // [R24]

endmodule

// File: csms_top.v
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "csms_map.vh"

// Function
// (R1) Supply rising past reset threshold clears the fault latch.
// (R2) Below lockout at start-up: low-side high, high-side low, no switching.
// (R3) Leaving lockout: sample code inputs, start slewing toward boot level.
// (R4) Supply dropping below lockout forces low-side drive high.
// (R5) Enable or system power-good low: shutdown, power-good low, clock-enable high.
// (R6) Shutdown ramps code to zero, one step per slew tick.
// (R7) At zero code: low-side high, high-side low, reference off.
// (R8) Power-good caused shutdown sets fault latch; enable toggle or supply cycle clears.
// (R9) Enable high powers reference; after reference ok, ramp from zero to boot.
// (R10) Release system power-good pin only after reference passes its lockout.
// (R11) Suspend low: output follows VID code; code change starts a transition.
// (R12) Processor changes all VID bits together within 1 us skew.
// (R13) System holds boot, suspend and on-time selects static.
// (R14) 50 us after power-good high at boot target: clock-enable low, go operating.
// (R15) Hold core power-good low 3 ms after clock enable, then high unless fault.
// (R16) Enable low: driver-disable low, output ground, low-side high, modulator off.
// (R17) Power-up mode: driver-disable high, boot code, wait for system power-good.
// (R18) Normal mode: driver-disable high, VID code without offset.
// (R19) Deep sleep: driver-disable low, VID plus offset, pulse skipping.
// (R20) Suspend: driver-disable low, suspend code, pulse skipping at light load.
// (R21) Under/over voltage, thermal or power-good fall latch fault; output held low.
// (R22) Suspend: driver-disable low 32 slew ticks after reaching final code.
// (R23) Suspend released: forced continuous, driver-disable high, slew to VID.
// (R24) Current code steps one per tick toward target; arrival when equal.
// (R25) Fault latch overrides every other mode input.
module csms_top #(
  parameter CW = 8,
  parameter PGOOD_CYC = `CSMS_PGOOD_CYC
) (
  input wire i_core_clk,
  input wire i_rst_n,
  // pins
  input wire i_enable_not_off,
  input wire i_system_power_good,
  output wire o_system_power_good,
  output reg o_system_power_good_oe,
  input wire i_suspend_request,
  input wire i_deep_sleep_not,
  input wire [5:0] i_vid_code,
  input wire [5:0] i_boot_code,
  input wire [5:0] i_suspend_code,
  input wire i_slew_clock_set,
  // analog comparator status
  input wire i_supply_above_reset,
  input wire i_supply_above_lockout,
  input wire i_reference_ok,
  input wire i_feedback_node_at_target,
  input wire i_output_under_fault,
  input wire i_output_over_fault,
  input wire i_thermal_fault,
  // drive and handshake outputs
  output reg o_low_side_drive,
  output reg o_high_side_drive,
  output reg o_modulator_enable,
  output reg o_reference_enable,
  output reg o_phase_drive_disable,
  output reg o_cpu_clock_enable_not,
  output reg o_core_power_good,
  output reg o_offset_enable,
  output reg o_skip_enable,
  output wire [CW-1:0] o_dac_code,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output reg o_pslverr
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [5:0] ST_LOCK = 6'h01;
  localparam [5:0] ST_OFF = 6'h02;
  localparam [5:0] ST_DOWN = 6'h04;
  localparam [5:0] ST_BOOT = 6'h08;
  localparam [5:0] ST_DELAY = 6'h10;
  localparam [5:0] ST_RUN = 6'h20;
  localparam integer CPU_CLOCK_ENABLE_NOT_INT = `CSMS_CPU_CLOCK_ENABLE_NOT_CYC;
  localparam integer PG_INT = PGOOD_CYC;
  // timers are 16 bits wide, counts cut to fit
  localparam [15:0] CPU_CLOCK_ENABLE_NOT_CYC = CPU_CLOCK_ENABLE_NOT_INT[15:0];
  localparam [15:0] PG_CYC = PG_INT[15:0];

  reg [5:0] state;
  reg [5:0] next_state;
  reg [15:0] cnt;
  reg [15:0] next_cnt;
  reg fault;
  reg [5:0] sus_cnt;
  reg [5:0] boot_q;
  reg [5:0] susp_q;
  reg slew_d;
  reg system_power_good_d;
  reg en_d;
  reg lock_d;
  reg skip_inhibit;
  reg [CW-1:0] target;
  wire arrived;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [29:0] sync1;
  reg [29:0] sync2;
  wire [29:0] raw = {i_enable_not_off, i_system_power_good, i_suspend_request,
    i_deep_sleep_not, i_vid_code, i_boot_code, i_suspend_code, i_slew_clock_set,
    i_supply_above_reset, i_supply_above_lockout, i_reference_ok,
    i_feedback_node_at_target, i_output_under_fault, i_output_over_fault, i_thermal_fault};

  // two flops on every pin
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 30'h0000_0000;
      sync2 <= 30'h0000_0000;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  wire en = sync2[29];
  wire system_power_good = sync2[28];
  wire suspend_request = sync2[27];
  wire deep_sleep_not_n = sync2[26];
  wire [5:0] vid = sync2[25:20];
  wire [5:0] boot_pin = sync2[19:14];
  wire [5:0] susp_pin = sync2[13:8];
  wire slew_pin = sync2[7];
  wire por_ok = sync2[6];
  wire lock_ok = sync2[5];
  wire ref_ok = sync2[4];
  wire fb_ok = sync2[3];
  wire uv = sync2[2];
  wire ov = sync2[1];
  wire therm = sync2[0];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slew_d <= 1'b0;
      system_power_good_d <= 1'b0;
      en_d <= 1'b0;
      lock_d <= 1'b0;
    end else begin
      slew_d <= slew_pin;
      system_power_good_d <= system_power_good;
      en_d <= en;
      lock_d <= lock_ok;
    end
  end

  wire tick = slew_pin & ~slew_d;
  wire system_power_good_fall = system_power_good_d & ~system_power_good;
  wire en_rise = en & ~en_d;
  wire lock_rise = lock_ok & ~lock_d;
  wire active = (state == ST_DELAY) || (state == ST_RUN);
  wire mod_on = ((state == ST_BOOT) && ref_ok) || active || (state == ST_DOWN);

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  wire fault_set = (mod_on & (uv | ov | therm)) | (active & system_power_good_fall); // [R21] [R8]
  wire fault_clr = ~por_ok | en_rise; // [R1] [R8]

  // set wins over clear
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fault <= 1'b0;
    end else if (fault_set) begin
      fault <= 1'b1;
    end else if (fault_clr) begin
      fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // code sampling on lockout exit
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_q <= 6'h00;
      susp_q <= 6'h00;
    end else if (lock_rise) begin
      boot_q <= boot_pin; // [R3]
      susp_q <= susp_pin; // [R3]
    end
  end

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  wire stop_boot = ~en | fault; // [R25]
  wire stop_run = ~en | fault | ~system_power_good; // [R5] [R25]

  // next state
  always @* begin
    next_state = state;
    case (state)
      ST_LOCK: begin
        if (lock_ok) begin
          next_state = (en && !fault) ? ST_BOOT : ST_OFF; // [R3]
        end
      end
      ST_OFF: begin
        if (en && !fault) begin
          next_state = ST_BOOT; // [R9]
        end
      end
      ST_DOWN: begin
        if (o_dac_code == {CW{1'b0}}) begin
          next_state = ST_OFF; // [R7]
        end
      end
      ST_BOOT: begin
        if (stop_boot) begin
          next_state = ST_DOWN;
        end else if (system_power_good && fb_ok && ref_ok && arrived) begin
          next_state = ST_DELAY; // [R14] [R17]
        end
      end
      ST_DELAY: begin
        if (stop_run) begin
          next_state = ST_DOWN; // [R5]
        end else if (cnt >= CPU_CLOCK_ENABLE_NOT_CYC - 16'h0001) begin
          next_state = ST_RUN; // [R14]
        end
      end
      ST_RUN: begin
        if (stop_run) begin
          next_state = ST_DOWN; // [R5]
        end
      end
      default: begin
        next_state = ST_LOCK;
      end
    endcase
    if (!lock_ok) begin
      next_state = ST_LOCK; // [R4]
    end
  end

  // shared timer, restarts on every state change
  always @* begin
    if (next_state != state) begin
      next_cnt = 16'h0000;
    end else if (cnt == 16'hFFFF) begin
      next_cnt = cnt;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // state and timer registers
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_LOCK;
      cnt <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // target selection and slew
  // ----------------------------------------
  wire [CW-1:0] vid_lvl = `CSMS_VID_TOP - {2'b00, vid};
  wire [CW-1:0] sus_lvl = `CSMS_SUS_TOP - {2'b00, susp_q};
  wire [CW-1:0] boot_lvl = `CSMS_BOOT_TOP - {2'b00, boot_q};

  // target follows mode
  always @* begin
    case (state)
      ST_BOOT: target = boot_lvl; // [R9] [R17]
      ST_DELAY: target = boot_lvl;
      ST_RUN: target = suspend_request ? sus_lvl : vid_lvl; // [R11] [R20] [R23]
      default: target = {CW{1'b0}}; // [R6] [R16]
    endcase
  end

  // no stepping in boot until reference is good
  wire slew_tick = tick & ~((state == ST_BOOT) & ~ref_ok); // [R9] [R6]
  wire slew_clear = (state == ST_LOCK) || (state == ST_OFF);

  csms_slew #(
    .W(CW)
  ) u_slew (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(slew_tick),
    .i_clear(slew_clear),
    .i_target(target),
    .o_code(o_dac_code),
    .o_arrived(arrived)
  );

  // ----------------------------------------
  // suspend settle counter
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sus_cnt <= 6'h00;
    end else if (!(state == ST_RUN) || !suspend_request || !arrived) begin
      sus_cnt <= 6'h00;
    end else if (tick && (sus_cnt != `CSMS_SUS_SKIP_TICKS)) begin
      sus_cnt <= sus_cnt + 6'h01; // [R22]
    end
  end

  // ----------------------------------------
  // output decode
  // ----------------------------------------
  reg next_ddo;
  reg next_skip;

  // driver disable and skip by mode
  always @* begin
    next_ddo = 1'b0; // [R16] [R21]
    next_skip = 1'b0;
    if ((state == ST_BOOT) || (state == ST_DELAY)) begin
      next_ddo = 1'b1; // [R17]
    end else if (state == ST_RUN) begin
      if (suspend_request) begin
        next_ddo = (sus_cnt < `CSMS_SUS_DDO_TICKS); // [R22] [R20]
        next_skip = (sus_cnt == `CSMS_SUS_SKIP_TICKS); // [R20]
      end else begin
        next_ddo = deep_sleep_not_n; // [R18] [R19] [R23]
        next_skip = ~deep_sleep_not_n; // [R19]
      end
    end
  end

  // registered pin outputs
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low_side_drive <= 1'b1;
      o_high_side_drive <= 1'b0;
      o_modulator_enable <= 1'b0;
      o_reference_enable <= 1'b0;
      o_phase_drive_disable <= 1'b0;
      o_cpu_clock_enable_not <= 1'b1;
      o_core_power_good <= 1'b0;
      o_offset_enable <= 1'b0;
      o_skip_enable <= 1'b0;
      o_system_power_good_oe <= 1'b1;
    end else begin
      o_low_side_drive <= ~mod_on; // [R2] [R4] [R7] [R16]
      o_high_side_drive <= 1'b0; // [R2] [R7]
      o_modulator_enable <= mod_on; // [R16]
      o_reference_enable <= (state != ST_LOCK) && (state != ST_OFF); // [R7] [R9]
      o_phase_drive_disable <= next_ddo;
      o_cpu_clock_enable_not <= ~(state == ST_RUN); // [R5] [R14]
      o_core_power_good <= (state == ST_RUN) && (cnt >= PG_CYC) && !fault; // [R15] [R5]
      o_offset_enable <= (state == ST_RUN) && !suspend_request && !deep_sleep_not_n; // [R19]
      o_skip_enable <= next_skip && !skip_inhibit;
      o_system_power_good_oe <= ~(o_reference_enable & ref_ok) | fault; // [R10]
    end
  end

  // open-drain pin only ever pulls low
  assign o_system_power_good = 1'b0;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr = i_psel & i_penable & i_pwrite;
  wire hit_ctrl = (i_paddr == `CSMS_REG_CTRL);
  wire hit_stat = (i_paddr == `CSMS_REG_STATUS);
  wire hit_code = (i_paddr == `CSMS_REG_CODE);

  // zero wait states
  assign o_pready = 1'b1;

  // control register write
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skip_inhibit <= `CSMS_CTRL_RESET;
    end else if (apb_wr && hit_ctrl) begin
      skip_inhibit <= i_pwdata[`CSMS_CTRL_SKIP_INHIBIT];
    end
  end

  // read data and error captured in setup phase
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (apb_setup) begin
      o_pslverr <= ~(hit_ctrl | hit_stat | hit_code);
      if (i_pwrite) begin
        o_prdata <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        o_prdata <= {31'h0000_0000, skip_inhibit};
      end else if (hit_stat) begin
        o_prdata <= {23'h00_0000, arrived, o_core_power_good, fault, state};
      end else if (hit_code) begin
        o_prdata <= {16'h0000, target, o_dac_code};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// File: csms_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: oscillator, power-good wire, cpu
// ----------------------------------------
module csms_partner (
  input wire i_core_clk,
  input wire i_chipset_ok,
  input wire i_pull_low_oe,
  input wire i_pull_data,
  input wire [5:0] i_vid_req,
  input wire [7:0] i_dac_code,
  output wire o_slew_clk,
  output wire o_power_good_wire,
  output wire [5:0] o_vid_code,
  output wire o_fb_at_target
);
  logic [1:0] div = 2'd0;
  logic slew_q = 1'b0;
  logic [5:0] vid_q = 6'h3F;
  // slew oscillator: one tick every eight core cycles; cpu code moves whole
  always @(posedge i_core_clk) begin
    div <= div + 2'd1;
    if (div == 2'd3)
      slew_q <= ~slew_q;
    vid_q <= i_vid_req; // all bits on one edge
  end
  assign o_slew_clk = slew_q;
  assign o_vid_code = vid_q;
  // pulled-up wire, low while any party pulls it
  assign o_power_good_wire = i_chipset_ok & ~(i_pull_low_oe & ~i_pull_data);
  // feedback follows the code once off ground
  assign o_fb_at_target = (i_dac_code != 8'h00);
endmodule

// File: csms_top_props.sv
`timescale 1ns/1ps
module csms_top_props #(
  parameter CW = 8,
  parameter PGOOD_CYC = 30000
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_enable_not_off,
  input wire i_system_power_good,
  input wire i_suspend_request,
  input wire i_deep_sleep_not,
  input wire i_supply_above_lockout,
  input wire i_reference_ok,
  input wire o_system_power_good_oe,
  input wire o_low_side_drive,
  input wire o_high_side_drive,
  input wire o_phase_drive_disable,
  input wire o_cpu_clock_enable_not,
  input wire o_core_power_good,
  input wire o_offset_enable,
  input wire [CW-1:0] o_dac_code
);
  int on_cyc;
  // cycles since the processor clock was enabled
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      on_cyc <= 0;
    else if (o_cpu_clock_enable_not)
      on_cyc <= 0;
    else if (on_cyc < PGOOD_CYC + 8)
      on_cyc <= on_cyc + 1;
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  shut_pgood_a: assert property (
    $fell(i_enable_not_off) |-> ##[1:5] (!o_core_power_good && o_cpu_clock_enable_not))
    else $error("no prompt shutdown");
  off_state_a: assert property (
    !i_enable_not_off [*5] |-> !o_phase_drive_disable && o_cpu_clock_enable_not && !o_core_power_good)
    else $error("outputs active while disabled");
  lockout_park_a: assert property (
    !i_supply_above_lockout [*6] |-> o_low_side_drive && !o_high_side_drive && o_dac_code == 0)
    else $error("drive not parked in lockout");
  one_step_a: assert property (
    i_supply_above_lockout && o_dac_code != $past(o_dac_code)
      |-> o_dac_code == $past(o_dac_code) + 1'b1 || o_dac_code + 1'b1 == $past(o_dac_code))
    else $error("code moved more than one step");
  pull_low_a: assert property (
    !i_reference_ok [*4] |-> o_system_power_good_oe)
    else $error("power-good wire released early");
  clock_on_a: assert property (
    $fell(o_cpu_clock_enable_not) |-> i_enable_not_off && $past(i_system_power_good, 400))
    else $error("clock enabled too soon");
  pgood_wait_a: assert property (
    $rose(o_core_power_good) |-> on_cyc >= PGOOD_CYC)
    else $error("core power-good rose early");
  pgood_due_a: assert property (
    on_cyc == PGOOD_CYC + 6 |-> o_core_power_good)
    else $error("core power-good late");
  deep_sleep_a: assert property (
    (i_system_power_good && !i_suspend_request && !i_deep_sleep_not && !o_cpu_clock_enable_not) [*6]
      |-> !o_phase_drive_disable && o_offset_enable)
    else $error("deep sleep outputs wrong");
  sus_exit_a: assert property (
    $fell(i_suspend_request) && i_enable_not_off |-> ##[2:5] o_phase_drive_disable)
    else $error("drive disable not released");
endmodule
bind csms_top csms_top_props #(.CW(CW), .PGOOD_CYC(PGOOD_CYC)) u_props (
  .i_core_clk, .i_rst_n, .i_enable_not_off, .i_system_power_good, .i_suspend_request, .i_deep_sleep_not,
  .i_supply_above_lockout, .i_reference_ok, .o_system_power_good_oe, .o_low_side_drive, .o_high_side_drive,
  .o_phase_drive_disable, .o_cpu_clock_enable_not, .o_core_power_good, .o_offset_enable, .o_dac_code);

// File: test_core_supply_mode_sequencer.sv
`timescale 1ns/1ps
module test_core_supply_mode_sequencer;
  localparam int PG = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic chip_ok = 1'b0;
  logic suspend_request = 1'b0;
  logic dsn = 1'b1;
  logic [5:0] vid_req = 6'h3F;
  logic sup_rst = 1'b1;
  logic sup_lock = 1'b0;
  logic ref_ok = 1'b0;
  logic under = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic rd_err;
  int err_count = 0;
  int n_checks = 0;
  int n;
  wire slew_clk, spg_wire, spg_out, spg_oe, fb_ok, pready, pslverr, low, high, mod_en, ref_en, phase_drive_disable, cpu_clock_enable_not_n;
  wire pgood, ofs, skip;
  wire [5:0] vid;
  wire [7:0] dac;
  wire [31:0] prdata;
  wire [2:0] watch;
  assign watch = {phase_drive_disable, pgood, cpu_clock_enable_not_n};
  csms_partner partner (.i_core_clk(clk), .i_chipset_ok(chip_ok), .i_pull_low_oe(spg_oe), .i_pull_data(spg_out),
    .i_vid_req(vid_req), .i_dac_code(dac), .o_slew_clk(slew_clk), .o_power_good_wire(spg_wire),
    .o_vid_code(vid), .o_fb_at_target(fb_ok));
  // boot and suspend selects strapped static
  csms_top #(.PGOOD_CYC(PG)) dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_enable_not_off(en),
    .i_system_power_good(spg_wire), .o_system_power_good(spg_out), .o_system_power_good_oe(spg_oe),
    .i_suspend_request(suspend_request), .i_deep_sleep_not(dsn), .i_vid_code(vid), .i_boot_code(6'h3F),
    .i_suspend_code(6'h3E), .i_slew_clock_set(slew_clk), .i_supply_above_reset(sup_rst),
    .i_supply_above_lockout(sup_lock), .i_reference_ok(ref_ok), .i_feedback_node_at_target(fb_ok),
    .i_output_under_fault(under), .i_output_over_fault(1'b0), .i_thermal_fault(1'b0),
    .o_low_side_drive(low), .o_high_side_drive(high), .o_modulator_enable(mod_en), .o_reference_enable(ref_en),
    .o_phase_drive_disable(phase_drive_disable), .o_cpu_clock_enable_not(cpu_clock_enable_not_n), .o_core_power_good(pgood),
    .o_offset_enable(ofs), .o_skip_enable(skip), .o_dac_code(dac), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks++;
      if (seen !== exp) begin
        err_count++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_dac(input logic [7:0] v);
    begin
      n = 0;
      while (dac !== v && n < 3000) begin
        @(posedge clk);
        n++;
      end
      chk(dac, v);
    end
  endtask
  task wait_lvl(input int s, input logic lvl);
    begin
      n = 0;
      while (watch[s] !== lvl && n < 3000) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
  // clock and watchdog
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({low, high, phase_drive_disable, cpu_clock_enable_not_n, pgood, spg_oe, spg_out, dac}, {7'b1001010, 8'h00});
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({pready, rd_err}, 2'b11);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd & 32'h0000_00FF, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0000);
    sup_lock <= 1'b1;
    repeat (20) @(posedge clk);
    chk({ref_en, spg_oe, dac}, {2'b11, 8'h00});
    ref_ok <= 1'b1;
    wait_dac(8'h1C);
    repeat (10) @(posedge clk);
    chk({phase_drive_disable, cpu_clock_enable_not_n, spg_oe, ofs}, 4'b1100);
    chip_ok <= 1'b1;
    wait_lvl(0, 1'b0);
    chk(n >= 500 && n <= 512, 1'b1);
    wait_lvl(1, 1'b1);
    chk(n >= PG - 1 && n <= PG + 4, 1'b1);
    wait_dac(8'h2C);
    chk({phase_drive_disable, ofs, pgood}, 3'b101);
    vid_req <= 6'h3E;
    wait_dac(8'h2D);
    dsn <= 1'b0;
    repeat (10) @(posedge clk);
    chk({phase_drive_disable, ofs, skip}, 3'b011);
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(skip, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0000);
    dsn <= 1'b1;
    repeat (10) @(posedge clk);
    chk({phase_drive_disable, ofs}, 2'b10);
    suspend_request <= 1'b1;
    wait_dac(8'h1D);
    wait_lvl(2, 1'b0);
    chk(n >= 240 && n <= 280, 1'b1);
    repeat (300) @(posedge clk);
    chk({skip, ofs, phase_drive_disable}, 3'b100);
    suspend_request <= 1'b0;
    repeat (6) @(posedge clk);
    chk(phase_drive_disable, 1'b1);
    wait_dac(8'h2D);
    chip_ok <= 1'b0;
    repeat (6) @(posedge clk);
    chk({pgood, cpu_clock_enable_not_n}, 2'b01);
    wait_dac(8'h00);
    repeat (10) @(posedge clk);
    chk({low, high, ref_en, phase_drive_disable, mod_en}, 5'b10000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd[6], 1'b1);
    chip_ok <= 1'b1;
    repeat (700) @(posedge clk);
    chk({dac, cpu_clock_enable_not_n}, {8'h00, 1'b1});
    en <= 1'b0;
    repeat (10) @(posedge clk);
    chk({phase_drive_disable, low, high, mod_en}, 4'b0100);
    en <= 1'b1;
    wait_dac(8'h1C);
    wait_dac(8'h2D);
    under <= 1'b1;
    wait_dac(8'h00);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk({rd[6], phase_drive_disable}, 2'b10);
    under <= 1'b0;
    sup_rst <= 1'b0;
    repeat (10) @(posedge clk);
    sup_rst <= 1'b1;
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd[6], 1'b0);
    sup_lock <= 1'b0;
    repeat (10) @(posedge clk);
    chk({low, high, dac}, {2'b10, 8'h00});
    stop_test;
  end
endmodule
